// >>> pkg/fcx_map.vh
// Function
// - Bit 0 of soft reset holds controller reset
// - Enable bits 0,1 gate line/code completion interrupts
// - Enable bits 2,3 gate recorder/image ready interrupts
// - Line size 00 1728, 01 2048 pixels
// - Line size 10 reduces 2048 by 9/11 in G3 transmit and G2/G3 conversion modes only
// - Output size sets recorder line and paper
// - Margin field: none, left, right, centered
// - Three-bit mode field selects seven modes
// - Command registers load reset values at reset
// - Four select lines pick register, eight data bits
// - Pending interrupts shown on interrupt request output except while controller reset held
`ifndef FCX_MAP_VH
`define FCX_MAP_VH

// Register offsets on the select lines
`define FCX_OFS_INT_EN      4'h0
`define FCX_OFS_STATUS      4'h1
`define FCX_OFS_MODE        4'h2
`define FCX_OFS_LINE_SIZE   4'h4
`define FCX_OFS_SOFT_RST    4'h6
`define FCX_OFS_OUT_FMT     4'h8

// Field positions
`define FCX_SRST_BIT        0
`define FCX_IEN_LSB         0
`define FCX_IEN_MSB         3
`define FCX_LSZ_LSB         0
`define FCX_LSZ_MSB         1
`define FCX_OSZ_LSB         0
`define FCX_OSZ_MSB         1
`define FCX_MRG_LSB         2
`define FCX_MRG_MSB         3
`define FCX_BLK_LSB         4
`define FCX_BLK_MSB         5
`define FCX_MODE_LSB        0
`define FCX_MODE_MSB        2

// Reset values
`define FCX_RST_INT_EN      8'h00
`define FCX_RST_MODE        8'h00
`define FCX_RST_LINE_SIZE   8'h00
`define FCX_RST_SOFT_RST    8'h00
`define FCX_RST_OUT_FMT     8'h00

// Line size codes and pixel counts
`define FCX_LSZ_SHORT       2'h0
`define FCX_LSZ_LONG        2'h1
`define FCX_LSZ_REDUCE      2'h2
`define FCX_PIX_SHORT       12'h6c0
`define FCX_PIX_LONG        12'h800

// Output size codes
`define FCX_OSZ_NARROW      2'h0
`define FCX_OSZ_WIDE_SHORT  2'h1
`define FCX_OSZ_UNDEF       2'h2
`define FCX_OSZ_WIDE_LONG   2'h3

// Margin codes and widths
`define FCX_MRG_NONE        2'h0
`define FCX_MRG_LEFT        2'h1
`define FCX_MRG_RIGHT       2'h2
`define FCX_MRG_CENTER      2'h3
`define FCX_MRG_FULL        9'h140
`define FCX_MRG_HALF        9'h0a0

// Edge blanking widths per code
`define FCX_BLK_NONE        2'h0
`define FCX_BLK_W1          6'h10
`define FCX_BLK_W2          6'h20
`define FCX_BLK_W3          6'h20

// Operating mode codes
`define FCX_MODE_COPY       3'h0
`define FCX_MODE_G3_TO_G2   3'h1
`define FCX_MODE_G2_TO_G3   3'h2
`define FCX_MODE_G3_RX      3'h3
`define FCX_MODE_G2_RX      3'h4
`define FCX_MODE_G3_TX      3'h5
`define FCX_MODE_G2_TX      3'h6
`define FCX_MODE_COUNT      7

// Synchroniser width: three strobes, four select lines, eight data bits
`define FCX_SYNC_W          15

`endif

// >>> verilog/fcx_sync.v
`timescale 1ns/1ps
module fcx_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rstn,
  // Asynchronous inputs and synchronised copies
  input  wire [W-1:0] async_in,
  input  wire [W-1:0] rst_val,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  // First stage feeds only the second stage; reset loads idle levels so no false strobe follows
  always @(posedge clk_sys) begin
    if (!rstn) begin
      meta_r   <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// >>> verilog/fcx_regs.v
`timescale 1ns/1ps
`include "fcx_map.vh"
module fcx_regs (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Host parallel bus
  input  wire        cs_n,
  input  wire        wr_n,
  input  wire        rd_n,
  input  wire [3:0]  reg_select_lines,
  input  wire [7:0]  data_in,
  output reg  [7:0]  data_out,
  output reg         data_oe,
  // Internal status flags from the engines
  input  wire [3:0]  status_flags,
  // Interrupt request
  output reg         irq,
  // Controller reset
  output reg         ctrl_rst,
  // Interrupt enables
  output reg  [3:0]  int_en,
  // Input line configuration
  output reg  [1:0]  line_size,
  output reg  [11:0] in_line_pixels,
  output reg         reduce_en,
  output reg         reduce_bad,
  // Recorder output format
  output reg  [1:0]  out_size,
  output reg  [11:0] out_line_bits,
  output reg         wide_paper,
  output reg         out_size_bad,
  output reg  [8:0]  margin_pre,
  output reg  [8:0]  margin_post,
  output reg         margin_bad,
  output reg  [5:0]  blank_bits,
  // Operating mode
  output reg  [2:0]  op_mode,
  output reg  [6:0]  mode_onehot,
  output reg         mode_bad
);

  // Synchronised host pins
  wire [`FCX_SYNC_W-1:0] pin_raw;
  wire [`FCX_SYNC_W-1:0] pin_s;
  wire                   cs_s_n;
  wire                   wr_s_n;
  wire                   rd_s_n;
  wire [3:0]             sel_s;
  wire [7:0]             din_s;

  assign pin_raw = {cs_n, wr_n, rd_n, reg_select_lines, data_in};

  fcx_sync #(
    .W        (`FCX_SYNC_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (pin_raw),
    .rst_val  ({`FCX_SYNC_W{1'b1}}),
    .sync_out (pin_s)
  );

  // A strobe held low through reset is ignored until both strobes are seen high
  reg armed_r;

  assign cs_s_n = pin_s[14];
  assign wr_s_n = pin_s[13];
  assign rd_s_n = pin_s[12];
  assign sel_s  = pin_s[11:8];
  assign din_s  = pin_s[7:0];

  // Write capture state
  reg        wr_act_r;
  reg [3:0]  wr_sel_r;
  reg [7:0]  wr_dat_r;
  wire       wr_act;
  wire       wr_done;

  assign wr_act  = armed_r & ~cs_s_n & ~wr_s_n;
  assign wr_done = wr_act_r & ~wr_act;

  // Command registers
  reg [7:0] int_en_r;
  reg [7:0] mode_r;
  reg [7:0] line_size_r;
  reg [7:0] soft_rst_r;
  reg [7:0] out_fmt_r;

  // Mode classification and margin/blank width lookups
  function mode_reduce_ok;
    input [2:0] m;
    begin
      mode_reduce_ok = (m == `FCX_MODE_G3_TX) || (m == `FCX_MODE_G2_TO_G3) ||
                       (m == `FCX_MODE_G3_TO_G2);
    end
  endfunction

  function [8:0] margin_front;
    input [1:0] c;
    begin
      case (c)
        `FCX_MRG_RIGHT:  margin_front = `FCX_MRG_FULL;
        `FCX_MRG_CENTER: margin_front = `FCX_MRG_HALF;
        default:         margin_front = 9'h000;
      endcase
    end
  endfunction

  function [8:0] margin_back;
    input [1:0] c;
    begin
      case (c)
        `FCX_MRG_LEFT:   margin_back = `FCX_MRG_FULL;
        `FCX_MRG_CENTER: margin_back = `FCX_MRG_HALF;
        default:         margin_back = 9'h000;
      endcase
    end
  endfunction

  function [5:0] blank_width;
    input [1:0] c;
    begin
      case (c)
        2'h1:    blank_width = `FCX_BLK_W1;
        2'h2:    blank_width = `FCX_BLK_W2;
        2'h3:    blank_width = `FCX_BLK_W3;
        default: blank_width = 6'h00;
      endcase
    end
  endfunction

  // Field views of the command registers
  wire [1:0] lsz_f;
  wire [1:0] osz_f;
  wire [1:0] mrg_f;
  wire [1:0] blk_f;
  wire [2:0] mode_f;
  wire       margin_ok;

  assign lsz_f     = line_size_r[`FCX_LSZ_MSB:`FCX_LSZ_LSB];
  assign osz_f     = out_fmt_r[`FCX_OSZ_MSB:`FCX_OSZ_LSB];
  assign mrg_f     = out_fmt_r[`FCX_MRG_MSB:`FCX_MRG_LSB];
  assign blk_f     = out_fmt_r[`FCX_BLK_MSB:`FCX_BLK_LSB];
  assign mode_f    = mode_r[`FCX_MODE_MSB:`FCX_MODE_LSB];
  // Margins on any other size would overrun the recorder line
  assign margin_ok = (osz_f == `FCX_OSZ_WIDE_SHORT);

  // Strobe arming and write capture
  always @(posedge clk_sys) begin
    if (!rstn) begin
      armed_r  <= 1'b0;
      wr_act_r <= 1'b0;
      wr_sel_r <= 4'h0;
      wr_dat_r <= 8'h00;
    end else begin
      if (wr_s_n & rd_s_n)
        armed_r <= 1'b1;
      wr_act_r <= wr_act;
      // Data is resampled every cycle the strobe is low, so the value present just before the rising edge is committed
      if (wr_act) begin
        wr_sel_r <= sel_s;
        wr_dat_r <= din_s;
      end
    end
  end

  // Register file, committed at the end of the write strobe
  always @(posedge clk_sys) begin
    if (!rstn) begin
      int_en_r    <= `FCX_RST_INT_EN;
      mode_r      <= `FCX_RST_MODE;
      line_size_r <= `FCX_RST_LINE_SIZE;
      soft_rst_r  <= `FCX_RST_SOFT_RST;
      out_fmt_r   <= `FCX_RST_OUT_FMT;
    end else if (wr_done) begin
      case (wr_sel_r)
        `FCX_OFS_INT_EN:    int_en_r    <= wr_dat_r;
        `FCX_OFS_MODE:      mode_r      <= wr_dat_r;
        `FCX_OFS_LINE_SIZE: line_size_r <= wr_dat_r;
        `FCX_OFS_SOFT_RST:  soft_rst_r  <= wr_dat_r;
        `FCX_OFS_OUT_FMT:   out_fmt_r   <= wr_dat_r;
        default:            soft_rst_r  <= soft_rst_r;
      endcase
    end
  end

  // Status readback at offset 1, driven only during a selected read
  wire rd_act;

  assign rd_act = armed_r & ~cs_s_n & ~rd_s_n & (sel_s == `FCX_OFS_STATUS);

  always @(posedge clk_sys) begin
    if (!rstn) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_oe  <= rd_act;
      data_out <= rd_act ? {4'h0, status_flags} : 8'h00;
    end
  end

  // Interrupt request from enabled flags
  wire [3:0] irq_src;

  assign irq_src[1:0] = status_flags[1:0] & int_en_r[1:0];
  assign irq_src[3:2] = status_flags[3:2] & int_en_r[3:2];

  always @(posedge clk_sys) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      // Held controller reset masks requests; engines are idle then
      irq <= (|irq_src) & ~soft_rst_r[`FCX_SRST_BIT];
    end
  end

  // Controller reset and enables
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_rst <= 1'b1;
      int_en   <= 4'h0;
    end else begin
      ctrl_rst <= soft_rst_r[`FCX_SRST_BIT];
      int_en   <= int_en_r[`FCX_IEN_MSB:`FCX_IEN_LSB];
    end
  end

  // Input line size and reduction
  always @(posedge clk_sys) begin
    if (!rstn) begin
      line_size      <= 2'h0;
      in_line_pixels <= `FCX_PIX_SHORT;
      reduce_en      <= 1'b0;
      reduce_bad     <= 1'b0;
    end else begin
      line_size <= lsz_f;
      case (lsz_f)
        `FCX_LSZ_SHORT: begin
          in_line_pixels <= `FCX_PIX_SHORT;
          reduce_en      <= 1'b0;
          reduce_bad     <= 1'b0;
        end
        `FCX_LSZ_LONG: begin
          in_line_pixels <= `FCX_PIX_LONG;
          reduce_en      <= 1'b0;
          reduce_bad     <= 1'b0;
        end
        `FCX_LSZ_REDUCE: begin
          // Reduction is only applied in a mode that permits it
          in_line_pixels <= `FCX_PIX_LONG;
          reduce_en      <= mode_reduce_ok(mode_f);
          reduce_bad     <= ~mode_reduce_ok(mode_f);
        end
        default: begin
          in_line_pixels <= `FCX_PIX_LONG;
          reduce_en      <= 1'b0;
          reduce_bad     <= 1'b1;
        end
      endcase
    end
  end

  // Recorder output format
  always @(posedge clk_sys) begin
    if (!rstn) begin
      out_size      <= 2'h0;
      out_line_bits <= `FCX_PIX_SHORT;
      wide_paper    <= 1'b0;
      out_size_bad  <= 1'b0;
      margin_pre    <= 9'h000;
      margin_post   <= 9'h000;
      margin_bad    <= 1'b0;
      blank_bits    <= 6'h00;
    end else begin
      out_size <= osz_f;
      case (osz_f)
        `FCX_OSZ_NARROW: begin
          out_line_bits <= `FCX_PIX_SHORT;
          wide_paper    <= 1'b0;
          out_size_bad  <= 1'b0;
        end
        `FCX_OSZ_WIDE_SHORT: begin
          out_line_bits <= `FCX_PIX_SHORT;
          wide_paper    <= 1'b1;
          out_size_bad  <= 1'b0;
        end
        `FCX_OSZ_WIDE_LONG: begin
          out_line_bits <= `FCX_PIX_LONG;
          wide_paper    <= 1'b1;
          out_size_bad  <= 1'b0;
        end
        default: begin
          // Undefined code keeps the safe narrow format and flags it
          out_line_bits <= `FCX_PIX_SHORT;
          wide_paper    <= 1'b0;
          out_size_bad  <= 1'b1;
        end
      endcase
      margin_pre  <= margin_ok ? margin_front(mrg_f) : 9'h000;
      margin_post <= margin_ok ? margin_back(mrg_f) : 9'h000;
      margin_bad  <= ~margin_ok & (mrg_f != `FCX_MRG_NONE);
      blank_bits  <= blank_width(blk_f);
    end
  end

  // Operating mode decode
  wire [6:0] mode_hot;

  genvar gi;
  generate
    for (gi = 0; gi < `FCX_MODE_COUNT; gi = gi + 1) begin : g_mode
      assign mode_hot[gi] = ({29'h0, mode_f} == gi);
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (!rstn) begin
      op_mode     <= `FCX_MODE_COPY;
      mode_onehot <= 7'h01;
      mode_bad    <= 1'b0;
    end else begin
      op_mode     <= mode_f;
      mode_onehot <= mode_hot;
      mode_bad    <= ~(|mode_hot);
    end
  end

endmodule

// >>> testbench/fcx_regs_monitor.sv
`timescale 1ns/1ps
module fcx_regs_monitor (
  // Clock and reset
  input wire        clk_sys,
  input wire        rstn,
  // Bus and flags
  input wire        rd_n,
  input wire        data_oe,
  input wire [3:0]  status_flags,
  // Watched outputs
  input wire        irq,
  input wire        ctrl_rst,
  input wire [3:0]  int_en,
  input wire [1:0]  line_size,
  input wire [11:0] in_line_pixels,
  input wire [1:0]  out_size,
  input wire [11:0] out_line_bits,
  input wire [8:0]  margin_pre,
  input wire [8:0]  margin_post,
  input wire [5:0]  blank_bits,
  input wire [2:0]  op_mode,
  input wire [6:0]  mode_onehot
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Enable port lags its register by one edge, hence the three-cycle windows
  wire hit = |(status_flags & int_en);
  a_irq_raised: assert property ((hit && !ctrl_rst && $stable(int_en)) [*3] |-> irq)
    else $error("irq not raised");
  a_irq_gated: assert property ((!hit) [*3] |-> !irq)
    else $error("irq without enabled flag");
  a_irq_held_rst: assert property (ctrl_rst [*3] |-> !irq)
    else $error("irq while soft reset held");
  a_pix_short: assert property ($stable(line_size) && line_size == 2'h0 |-> in_line_pixels == 12'h6c0)
    else $error("short line count wrong");
  a_pix_long: assert property ($stable(line_size) && line_size != 2'h0 |-> in_line_pixels == 12'h800)
    else $error("long line count wrong");
  a_out_bits: assert property ($stable(out_size) |-> out_line_bits == ((out_size == 2'h3) ? 12'h800 : 12'h6c0))
    else $error("recorder line length wrong");
  a_margin_gate: assert property ($stable(out_size) && out_size != 2'h1 |-> margin_pre == 9'h0 && margin_post == 9'h0)
    else $error("margin outside wide short format");
  a_margin_split: assert property (margin_pre != 9'h0 && margin_post != 9'h0 |-> margin_pre == 9'h0a0 && margin_post == 9'h0a0)
    else $error("centered margin wrong");
  a_blank_width: assert property (blank_bits == 6'h0 || blank_bits == 6'h10 || blank_bits == 6'h20)
    else $error("blank width illegal");
  a_mode_hot: assert property ($stable(op_mode) && op_mode != 3'h7 |-> mode_onehot == (7'h01 << op_mode))
    else $error("mode decode wrong");
  a_bus_idle: assert property (rd_n [*4] |-> !data_oe)
    else $error("bus driven without read");
  a_hw_reset: assert property (disable iff (1'b0) !rstn |=> ctrl_rst && int_en == 4'h0 && !irq && !data_oe)
    else $error("reset state wrong");
  c_irq: cover property (irq);
  c_read: cover property (data_oe);
  c_center: cover property (margin_pre == 9'h0a0);
endmodule

// >>> testbench/fcx_host_model.sv
`timescale 1ns/1ps
module fcx_host_model (
  // Clock and readback
  input  wire       clk_sys,
  input  wire [7:0] data_out,
  input  wire       data_oe,
  // Bus toward the device
  output reg        cs_n,
  output reg        wr_n,
  output reg        rd_n,
  output reg  [3:0] sel,
  output reg  [7:0] hd
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    sel = 4'h0;
    hd = 8'h5a;
  end
  // Low three cycles, high six so derived outputs have settled
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(negedge clk_sys);
      cs_n = 1'b0;
      wr_n = 1'b0;
      sel = a;
      hd = v;
      repeat (3) @(negedge clk_sys);
      cs_n = 1'b1;
      wr_n = 1'b1;
      hd = ~v;
      repeat (6) @(negedge clk_sys);
    end
  endtask
  task rd(input [3:0] a, output [7:0] v, output oe);
    begin
      @(negedge clk_sys);
      cs_n = 1'b0;
      rd_n = 1'b0;
      sel = a;
      repeat (4) @(negedge clk_sys);
      v = data_out;
      oe = data_oe;
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule

// >>> testbench/tb_fcx_regs.sv
`timescale 1ns/1ps
module tb_fcx_regs;
  reg         clk_sys = 1'b0;
  reg         rstn = 1'b0;
  reg  [3:0]  status_flags = 4'h0;
  integer     fail_count = 0;
  integer     check_count = 0;
  wire        cs_n, wr_n, rd_n, data_oe, irq, ctrl_rst, reduce_en, reduce_bad;
  wire        wide_paper, out_size_bad, margin_bad, mode_bad;
  wire [3:0]  reg_select_lines, int_en;
  wire [7:0]  hd, data_out;
  wire [1:0]  line_size, out_size;
  wire [11:0] in_line_pixels, out_line_bits;
  wire [8:0]  margin_pre, margin_post;
  wire [5:0]  blank_bits;
  wire [2:0]  op_mode;
  wire [6:0]  mode_onehot;
  // Shared data wire: device wins while it drives
  wire [7:0]  data_in = data_oe ? data_out : hd;
  always #5 clk_sys = ~clk_sys;
  fcx_host_model h (.clk_sys, .data_out, .data_oe, .cs_n, .wr_n, .rd_n, .sel(reg_select_lines), .hd);
  fcx_regs uut (.clk_sys, .rstn, .cs_n, .wr_n, .rd_n, .reg_select_lines, .data_in, .data_out, .data_oe,
    .status_flags, .irq, .ctrl_rst, .int_en, .line_size, .in_line_pixels, .reduce_en, .reduce_bad,
    .out_size, .out_line_bits, .wide_paper, .out_size_bad, .margin_pre, .margin_post, .margin_bad,
    .blank_bits, .op_mode, .mode_onehot, .mode_bad);
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task t_soft;
    begin
      h.wr(4'h6, 8'h01);
      chk(ctrl_rst, 1'b1);
      h.wr(4'h0, 8'h01);
      status_flags = 4'h1;
      repeat (3) @(negedge clk_sys);
      chk(irq, 1'b0);
      h.wr(4'h6, 8'h00);
      chk({ctrl_rst, irq}, 2'b01);
      status_flags = 4'h0;
      repeat (3) @(negedge clk_sys);
      chk(irq, 1'b0);
    end
  endtask
  task t_irq;
    integer i;
    reg [3:0] b;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        b = 4'h1 << i;
        h.wr(4'h0, {4'h0, b});
        status_flags = ~b;
        repeat (3) @(negedge clk_sys);
        chk({int_en, irq}, {b, 1'b0});
        status_flags = b;
        repeat (3) @(negedge clk_sys);
        chk(irq, 1'b1);
      end
      status_flags = 4'hf;
      h.wr(4'h0, 8'h00);
      chk(irq, 1'b0);
      status_flags = 4'h0;
    end
  endtask
  // Reduction code is only legal in the modes that allow it
  task lsz(input [2:0] m, input [1:0] c, input [13:0] exp);
    begin
      h.wr(4'h2, {5'h0, m});
      h.wr(4'h4, {6'h0, c});
      chk({in_line_pixels, reduce_en, reduce_bad}, exp);
    end
  endtask
  task t_line;
    begin
      lsz(3'h0, 2'h0, {12'h6c0, 2'b00});
      lsz(3'h3, 2'h1, {12'h800, 2'b00});
      lsz(3'h5, 2'h3, {12'h800, 2'b01});
      lsz(3'h5, 2'h2, {12'h800, 2'b10});
      lsz(3'h2, 2'h2, {12'h800, 2'b10});
      lsz(3'h1, 2'h2, {12'h800, 2'b10});
      h.wr(4'h2, 8'h00);
      chk(reduce_bad, 1'b1);
    end
  endtask
  task t_out;
    integer c;
    reg [8:0] pre_e;
    reg [8:0] post_e;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        h.wr(4'h8, c[7:0]);
        chk(out_size, c[1:0]);
        chk({out_line_bits, wide_paper, out_size_bad}, {(c == 3) ? 12'h800 : 12'h6c0, c[0], c == 2});
        h.wr(4'h8, {4'h0, c[1:0], 2'h1});
        pre_e = (c == 2) ? 9'h140 : (c == 3) ? 9'h0a0 : 9'h000;
        post_e = (c == 1) ? 9'h140 : (c == 3) ? 9'h0a0 : 9'h000;
        chk({margin_pre, margin_post, margin_bad}, {pre_e, post_e, 1'b0});
        h.wr(4'h8, {2'h0, c[1:0], 4'h0});
        chk(blank_bits, (c == 0) ? 6'h0 : (c == 1) ? 6'h10 : 6'h20);
      end
      h.wr(4'h8, 8'h0c);
      chk({margin_pre, margin_post, margin_bad}, {18'h0, 1'b1});
    end
  endtask
  task t_mode;
    integer c;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        h.wr(4'h2, c[7:0]);
        chk({op_mode, mode_bad}, {c[2:0], c == 7});
        if (c < 7) begin
          chk(mode_onehot, 7'h01 << c);
        end
      end
    end
  endtask
  task t_bus;
    reg [7:0] v;
    reg oe;
    begin
      h.wr(4'h2, 8'h05);
      h.wr(4'ha, 8'hff);
      h.wr(4'h3, 8'hff);
      chk({op_mode, int_en, line_size}, {3'h5, 4'h0, 2'h2});
      status_flags = 4'ha;
      h.rd(4'h1, v, oe);
      chk({oe, v}, {1'b1, 8'h0a});
      h.rd(4'h2, v, oe);
      chk(oe, 1'b0);
    end
  endtask
  task chk_rst;
    begin
      chk({ctrl_rst, int_en, line_size, out_size, op_mode, irq, data_oe}, 24'h0);
      chk({in_line_pixels, mode_onehot}, {12'h6c0, 7'h01});
    end
  endtask
  // Mid-run reset with programmed registers and a pending request
  task t_rst;
    begin
      h.wr(4'h0, 8'h0f);
      chk(irq, 1'b1);
      rstn = 1'b0;
      repeat (3) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk_rst;
      h.wr(4'h0, 8'h04);
      chk(int_en, 4'h4);
      status_flags = 4'h0;
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_rst;
    t_soft;
    t_irq;
    t_line;
    t_out;
    t_mode;
    t_bus;
    t_rst;
    summarize;
  end
  initial begin
    #50000;
    fail_count = fail_count + 1;
    summarize;
  end
endmodule
bind fcx_regs fcx_regs_monitor mon (.clk_sys, .rstn, .rd_n, .data_oe, .status_flags, .irq, .ctrl_rst,
  .int_en, .line_size, .in_line_pixels, .out_size, .out_line_bits, .margin_pre, .margin_post,
  .blank_bits, .op_mode, .mode_onehot);
